// ### pitd_filt_if.sv
// carrier between decoder core and terminal filter
`timescale 1ns/1ps
interface pitd_filt_if #(
  parameter int N  = 11,
  parameter int TW = 10
);
  logic [N-1:0]  raw;
  logic          tick;
  logic [TW-1:0] tc;
  logic [N-1:0]  level;
  logic [N-1:0]  rise;

  modport core (output raw, output tick, output tc, input level, input rise);
  modport filt (input raw, input tick, input tc, output level, output rise);
endinterface : pitd_filt_if

// ### pitd_filter.sv
// per-terminal time-constant filter with rising-edge pulses
`timescale 1ns/1ps
module pitd_filter #(
  parameter int N  = 11,
  parameter int TW = 10
) (
  input  wire logic   clk_i,   // core clock
  input  wire logic   rst_n_i, // synchronised reset, active low
  pitd_filt_if.filt   f        // raw levels in, filtered levels out
);
  import pitd_pkg::*;

  logic [N-1:0] lvl_r;
  logic [N-1:0] rise_r;

  assign f.level = lvl_r;
  assign f.rise  = rise_r;

  for (genvar i = 0; i < N; i++)
  begin : g_term
    logic [TW-1:0] cnt_r;
    logic [TW-1:0] cnt_nxt;
    logic          done_w;
    assign cnt_nxt = cnt_r + 1'b1;
    assign done_w  = f.tick && (cnt_nxt >= f.tc);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        cnt_r     <= '0;
        lvl_r[i]  <= 1'b0;
        rise_r[i] <= 1'b0;
      end
      else
      begin
        rise_r[i] <= (f.raw[i] != lvl_r[i]) && done_w && f.raw[i];
        if (f.raw[i] == lvl_r[i])
          cnt_r <= '0;
        else if (done_w)
        begin
          lvl_r[i] <= f.raw[i];
          cnt_r    <= '0;
        end
        else if (f.tick)
          cnt_r <= cnt_nxt;
      end
    end
  end

endmodule : pitd_filter

// ### pitd_map.svh
// register map, field positions, reset values and timing constants
`ifndef PITD_MAP_SVH
`define PITD_MAP_SVH

`define PITD_IDX_W          4
`define PITD_REG_STATUS     4'h0
`define PITD_REG_SEL_BASE   4'h1
`define PITD_REG_FILT       4'h9
`define PITD_REG_CFG        4'hA
`define PITD_REG_STATE      4'hB
`define PITD_REG_MAXF       4'hC
`define PITD_REG_UDF        4'hD

`define PITD_CFG_TRIP_NC    0
`define PITD_CFG_MMC_ILOCK  1
`define PITD_CFG_UD_SAVE    2
`define PITD_CFG_RESET      3'h0

`define PITD_FILT_MS_DEF    10'h00F
`define PITD_FILT_MS_MIN    10'h002
`define PITD_FILT_MS_MAX    10'h3E8
`define PITD_MAXF_RESET     16'h1770
`define PITD_UD_STEP        16'h0001

`define PITD_CLK_PERIOD_NS  10
`define PITD_MS_IN_NS       1000000
`define PITD_CYC_PER_MS     (`PITD_MS_IN_NS / `PITD_CLK_PERIOD_NS)

`endif

// ### pitd_pkg.sv
// types shared by the input terminal decoder
package pitd_pkg;

  typedef enum logic [5:0] {
    FN_SPEED_L, FN_SPEED_M, FN_SPEED_H, FN_RAMP_L, FN_RAMP_M, FN_RAMP_H,
    FN_DC_INJECTION_BRAKE, FN_SECOND_SET, FN_EXCHANGE, FN_RSV_0, FN_UP, FN_DOWN,
    FN_THREE_WIRE, FN_EXT_TRIP, FN_RSV_1, FN_INT_CLEAR, FN_OPEN_LOOP,
    FN_LOCAL_REMOTE_SELECT, FN_ANA_HOLD, FN_RAMP_STOP, FN_SECOND_PROPORTIONAL_GAIN, FN_RSV_2,
    FN_ILOCK_1, FN_ILOCK_2, FN_ILOCK_3, FN_ILOCK_4, FN_SPEED_X,
    FN_FAULT_RESET, FN_ESTOP, FN_JOG, FN_FWD, FN_REV, FN_ANA_CHANGE,
    FN_PRE_EXCITE, FN_EXT_PID, FN_UD_CLEAR
  } pitd_func_t;

  typedef enum logic [1:0] {
    PX_IDLE,
    PX_EXCITE,
    PX_NORMAL
  } pitd_px_state_t;

  localparam pitd_func_t PITD_SEL_DEFAULT [8] = '{
    FN_SPEED_L, FN_SPEED_M, FN_SPEED_H, FN_FAULT_RESET,
    FN_ESTOP, FN_JOG, FN_FWD, FN_REV
  };

endpackage : pitd_pkg

// ### pitd_switches.sv
// contact model: terminal pins that chatter back for one cycle after each change
`timescale 1ns/1ps
module pitd_switches (
  input  wire logic       clk_i,  // core clock
  input  wire logic [7:0] want_i, // contact positions
  input  wire logic [2:0] sub_i,  // sub-board positions
  output logic      [7:0] term_o, // terminal pins
  output logic      [2:0] sub_o   // sub-board pins
);
  logic [7:0] p1_r = 8'h00;
  logic [7:0] p2_r = 8'h00;
  always @(posedge clk_i)
  begin
    p1_r   <= want_i;
    p2_r   <= p1_r;
    term_o <= (p1_r != p2_r) ? p2_r : want_i;
    sub_o  <= sub_i;
  end
endmodule : pitd_switches

// ### pitd_top.sv
// programmable input terminal decoder with avalon-mm register slave
`timescale 1ns/1ps
`include "pitd_map.svh"
module pitd_top #(
  parameter int CYC_PER_MS = `PITD_CYC_PER_MS
) (
  input  wire logic        core_clk_i,          // 100 MHz core clock
  input  wire logic        rst_n_i,             // async reset, active low
  input  wire logic [5:0]  avs_address_i,       // byte address
  input  wire logic        avs_read_i,          // read request
  input  wire logic        avs_write_i,         // write request
  input  wire logic [31:0] avs_writedata_i,     // write data
  output logic      [31:0] avs_readdata_o,      // read data
  output logic             avs_waitrequest_o,   // stall
  input  wire logic [7:0]  input_terminal_i,    // terminals 1..8
  input  wire logic [2:0]  sub_board_input_i,   // sub-board a, b, c
  input  wire logic        sub_board_fitted_i,  // sub-board present
  input  wire logic        drive_stopped_i,     // core reports stop
  output logic      [3:0]  step_index_o,        // preset step select
  output logic      [2:0]  ramp_index_o,        // accel/decel pair select
  output logic             jog_o,               // jog run
  output logic             run_fwd_o,           // forward run command
  output logic             run_rev_o,           // reverse run command
  output logic             emergency_stop_o,    // emergency stop level
  output logic             fault_reset_o,       // fault reset pulse
  output logic             output_cut_o,        // inhibit drive output
  output logic             ext_trip_fault_o,    // latched trip fault
  output logic             dc_injection_brake_o, // dc braking request
  output logic             second_parameter_set_o, // second set active
  output logic             inv_line_contactor_o,  // drive-line contactor
  output logic             comm_line_contactor_o, // commercial contactor
  output logic      [15:0] up_down_freq_o,      // up/down speed
  output logic             integral_clear_o,    // clear pid integral
  output logic             open_loop_o,         // v/f instead of pid
  output logic             local_remote_select_o, // remote sources
  output logic             analog_hold_o,       // freeze frequency
  output logic             ramp_stop_o,         // hold speed
  output logic             second_proportional_gain_o, // alt p gain
  output logic      [3:0]  pump_interlock_o,    // interlock inputs
  output logic             current_input_sel_o, // current instead of voltage_input
  output logic             pre_excite_o,        // magnetising current
  output logic             external_pid_enable_o, // external pid run
  output logic             up_down_save_clear_o // stored freq erased pulse
);
  import pitd_pkg::*;

  logic              rst_q1_r;
  logic              rst_n;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      {rst_n, rst_q1_r} <= 2'b00;
    else
      {rst_n, rst_q1_r} <= {rst_q1_r, 1'b1};
  end

  // pin synchronisers, bit 11 is the sub-board present strap
  logic [11:0]       sync1_r;
  logic [11:0]       sync2_r;
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {sub_board_fitted_i, sub_board_input_i, input_terminal_i};
      sync2_r <= sync1_r;
    end
  end

  // millisecond tick for the filter and up/down ramp
  logic [31:0]       div_r;
  logic              tick_w;
  assign tick_w = (div_r == 32'(CYC_PER_MS - 1));
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= '0;
    else
      div_r <= tick_w ? '0 : div_r + 1'b1;
  end

  pitd_filt_if #(.N(11), .TW(10)) fif ();
  logic [9:0]        filt_ms_r;
  assign fif.raw  = sync2_r[10:0];
  assign fif.tick = tick_w;
  assign fif.tc   = filt_ms_r;

  pitd_filter #(.N(11), .TW(10)) u_filter (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .f       (fif)
  );

  // registers
  pitd_func_t        sel_r [8];
  logic [2:0]        cfg_r;
  logic [15:0]       maxf_r;
  logic              ack_r;
  logic [31:0]       rdata_r;
  logic [3:0]        idx_w;
  logic              req_w;
  logic              wr_ok_w;
  logic [7:0]        lvl8;
  logic [7:0]        rise8;
  logic [3:0]        claim_w;

  assign lvl8    = fif.level[7:0];
  assign rise8   = fif.rise[7:0];
  assign claim_w = cfg_r[`PITD_CFG_MMC_ILOCK] ? 4'hF : 4'h0;

  // selects and claim come in as arguments so every caller re-evaluates when they change
  function automatic logic [7:0] term_match(input pitd_func_t fn,
                                            input pitd_func_t sel [8],
                                            input logic [3:0] claim);
    logic [7:0] m;
    m = '0;
    for (int k = 0; k < 8; k++)
      m[k] = (sel[k] == fn) && !(k < 4 && claim[k]);
    return m;
  endfunction : term_match

  logic on_sl, on_sm, on_sh, on_sx, on_rl, on_rm, on_rh, on_dc, on_2nd, on_exch;
  logic on_up, on_dn, on_3w, on_icl, on_ol, on_lr, on_ah, on_rs, on_pg2;
  logic on_rst, on_estop, on_jog, on_fwd, on_rev, on_ana, on_pre, on_epid;
  logic trip_used, trip_lvl, trip_act;
  logic rise_rst, rise_fwd, rise_rev, rise_udc;
  assign on_sl     = |(term_match(FN_SPEED_L, sel_r, claim_w) & lvl8);
  assign on_sm     = |(term_match(FN_SPEED_M, sel_r, claim_w) & lvl8);
  assign on_sh     = |(term_match(FN_SPEED_H, sel_r, claim_w) & lvl8);
  assign on_sx     = |(term_match(FN_SPEED_X, sel_r, claim_w) & lvl8);
  assign on_rl     = |(term_match(FN_RAMP_L, sel_r, claim_w) & lvl8);
  assign on_rm     = |(term_match(FN_RAMP_M, sel_r, claim_w) & lvl8);
  assign on_rh     = |(term_match(FN_RAMP_H, sel_r, claim_w) & lvl8);
  assign on_dc     = |(term_match(FN_DC_INJECTION_BRAKE, sel_r, claim_w) & lvl8);
  assign on_2nd    = |(term_match(FN_SECOND_SET, sel_r, claim_w) & lvl8);
  assign on_exch   = |(term_match(FN_EXCHANGE, sel_r, claim_w) & lvl8);
  assign on_up     = |(term_match(FN_UP, sel_r, claim_w) & lvl8);
  assign on_dn     = |(term_match(FN_DOWN, sel_r, claim_w) & lvl8);
  assign on_3w     = |(term_match(FN_THREE_WIRE, sel_r, claim_w) & lvl8);
  assign on_icl    = |(term_match(FN_INT_CLEAR, sel_r, claim_w) & lvl8);
  assign on_ol     = |(term_match(FN_OPEN_LOOP, sel_r, claim_w) & lvl8);
  assign on_lr     = |(term_match(FN_LOCAL_REMOTE_SELECT, sel_r, claim_w) & lvl8);
  assign on_ah     = |(term_match(FN_ANA_HOLD, sel_r, claim_w) & lvl8);
  assign on_rs     = |(term_match(FN_RAMP_STOP, sel_r, claim_w) & lvl8);
  assign on_pg2    = |(term_match(FN_SECOND_PROPORTIONAL_GAIN, sel_r, claim_w) & lvl8);
  assign on_rst    = |(term_match(FN_FAULT_RESET, sel_r, claim_w) & lvl8);
  assign on_estop  = |(term_match(FN_ESTOP, sel_r, claim_w) & lvl8);
  assign on_jog    = |(term_match(FN_JOG, sel_r, claim_w) & lvl8);
  assign on_fwd    = |(term_match(FN_FWD, sel_r, claim_w) & lvl8);
  assign on_rev    = |(term_match(FN_REV, sel_r, claim_w) & lvl8);
  assign on_ana    = |(term_match(FN_ANA_CHANGE, sel_r, claim_w) & lvl8);
  assign on_pre    = |(term_match(FN_PRE_EXCITE, sel_r, claim_w) & lvl8);
  assign on_epid   = |(term_match(FN_EXT_PID, sel_r, claim_w) & lvl8);
  assign trip_used = |term_match(FN_EXT_TRIP, sel_r, claim_w);
  assign trip_lvl  = |(term_match(FN_EXT_TRIP, sel_r, claim_w) & lvl8);
  assign trip_act  = trip_used && (trip_lvl ^ cfg_r[`PITD_CFG_TRIP_NC]);
  assign rise_rst  = |(term_match(FN_FAULT_RESET, sel_r, claim_w) & rise8);
  assign rise_fwd  = |(term_match(FN_FWD, sel_r, claim_w) & rise8);
  assign rise_rev  = |(term_match(FN_REV, sel_r, claim_w) & rise8);
  assign rise_udc  = |(term_match(FN_UD_CLEAR, sel_r, claim_w) & rise8);

  // avalon slave: one wait cycle, then answer
  assign req_w             = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req_w && !ack_r;
  assign avs_readdata_o    = rdata_r;
  assign idx_w             = avs_address_i[5:2];
  assign wr_ok_w           = avs_write_i && ack_r && !on_estop;

  logic [10:0]       status_w;
  logic [31:0]       rd_mux_w;
  logic [9:0]        filt_wd_w;
  logic [9:0]        filt_cl_w;
  logic [3:0]        sel_off_w;
  assign status_w  = {sync2_r[11] ? fif.level[10:8] : 3'h0, lvl8};
  assign filt_wd_w = avs_writedata_i[9:0];
  assign filt_cl_w = (avs_writedata_i[31:10] != '0 || filt_wd_w > `PITD_FILT_MS_MAX)
                     ? `PITD_FILT_MS_MAX
                     : (filt_wd_w < `PITD_FILT_MS_MIN ? `PITD_FILT_MS_MIN : filt_wd_w);
  assign sel_off_w = idx_w - `PITD_REG_SEL_BASE;

  logic              trip_r;
  logic              fwd_lat_r;
  logic              rev_lat_r;
  pitd_px_state_t    px_r;
  pitd_px_state_t    px_nxt;

  always_comb
  begin
    rd_mux_w = '0;
    if (idx_w >= `PITD_REG_SEL_BASE && idx_w < `PITD_REG_FILT)
      rd_mux_w = {26'h000_0000, sel_r[sel_off_w[2:0]]};
    else if (idx_w == `PITD_REG_STATUS)
      rd_mux_w = {21'h00_0000, status_w};
    else if (idx_w == `PITD_REG_FILT)
      rd_mux_w = {22'h00_0000, filt_ms_r};
    else if (idx_w == `PITD_REG_CFG)
      rd_mux_w = {29'h0000_0000, cfg_r};
    else if (idx_w == `PITD_REG_STATE)
      rd_mux_w = {24'h00_0000, second_parameter_set_o, open_loop_o, pre_excite_o,
                  rev_lat_r, fwd_lat_r, on_estop, output_cut_o, trip_r};
    else if (idx_w == `PITD_REG_MAXF)
      rd_mux_w = {16'h0000, maxf_r};
    else if (idx_w == `PITD_REG_UDF)
      rd_mux_w = {16'h0000, up_down_freq_o};
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r     <= 1'b0;
      rdata_r   <= '0;
      sel_r     <= PITD_SEL_DEFAULT;
      filt_ms_r <= `PITD_FILT_MS_DEF;
      cfg_r     <= `PITD_CFG_RESET;
      maxf_r    <= `PITD_MAXF_RESET;
    end
    else
    begin
      ack_r <= req_w && !ack_r;
      if (avs_read_i && !ack_r)
        rdata_r <= rd_mux_w;
      if (wr_ok_w)
      begin
        if (idx_w >= `PITD_REG_SEL_BASE && idx_w < `PITD_REG_FILT
            && avs_writedata_i[5:0] <= FN_UD_CLEAR)
          sel_r[sel_off_w[2:0]] <= pitd_func_t'(avs_writedata_i[5:0]);
        if (idx_w == `PITD_REG_FILT)
          filt_ms_r <= filt_cl_w;
        if (idx_w == `PITD_REG_CFG)
          cfg_r <= avs_writedata_i[2:0];
        if (idx_w == `PITD_REG_MAXF)
          maxf_r <= avs_writedata_i[15:0];
      end
    end
  end

  // run, trip, contactor and up/down state
  logic [15:0]       ud_up_w;
  logic [15:0]       ud_dn_w;
  logic              run_w;
  assign ud_up_w = (maxf_r - up_down_freq_o < `PITD_UD_STEP) ? maxf_r
                   : up_down_freq_o + `PITD_UD_STEP;
  assign ud_dn_w = (up_down_freq_o < `PITD_UD_STEP) ? 16'h0000
                   : up_down_freq_o - `PITD_UD_STEP;
  assign run_w   = on_3w ? (fwd_lat_r || rev_lat_r) : (on_fwd || on_rev);

  always_comb
  begin
    px_nxt = px_r;
    unique case (px_r)
      PX_IDLE:   if (on_pre && !run_w) px_nxt = PX_EXCITE;
      PX_EXCITE: if (run_w) px_nxt = PX_NORMAL;
                 else if (!on_pre) px_nxt = PX_IDLE;
      PX_NORMAL: if (!run_w && !on_pre) px_nxt = PX_IDLE;
      default:   px_nxt = PX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trip_r                 <= 1'b0;
      fwd_lat_r              <= 1'b0;
      rev_lat_r              <= 1'b0;
      px_r                   <= PX_IDLE;
      up_down_freq_o         <= '0;
      second_parameter_set_o <= 1'b0;
      open_loop_o            <= 1'b0;
      inv_line_contactor_o   <= 1'b0;
      comm_line_contactor_o  <= 1'b0;
    end
    else
    begin
      px_r <= px_nxt;
      if (trip_act)
        trip_r <= 1'b1;
      else if (rise_rst)
        trip_r <= 1'b0;
      if (rise_fwd)
        fwd_lat_r <= 1'b1;
      else if (!on_3w || rise_rev)
        fwd_lat_r <= 1'b0;
      if (rise_rev)
        rev_lat_r <= 1'b1;
      else if (!on_3w || rise_fwd)
        rev_lat_r <= 1'b0;
      if (drive_stopped_i)
      begin
        second_parameter_set_o <= on_2nd;
        open_loop_o            <= on_ol;
      end
      inv_line_contactor_o  <= !on_exch && !comm_line_contactor_o;
      comm_line_contactor_o <= on_exch && !inv_line_contactor_o;
      if (rise_udc && cfg_r[`PITD_CFG_UD_SAVE])
        up_down_freq_o <= '0;
      else if (up_down_freq_o > maxf_r)
        up_down_freq_o <= maxf_r;
      else if (tick_w && on_up && !on_dn)
        up_down_freq_o <= ud_up_w;
      else if (tick_w && on_dn && !on_up)
        up_down_freq_o <= ud_dn_w;
    end
  end

  // registered level and pulse outputs to the drive core
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {step_index_o, ramp_index_o, jog_o, run_fwd_o, run_rev_o} <= '0;
      {emergency_stop_o, fault_reset_o, output_cut_o, ext_trip_fault_o} <= '0;
      {dc_injection_brake_o, integral_clear_o, local_remote_select_o} <= '0;
      {analog_hold_o, ramp_stop_o, second_proportional_gain_o} <= '0;
      {pump_interlock_o, current_input_sel_o, pre_excite_o} <= '0;
      {external_pid_enable_o, up_down_save_clear_o} <= '0;
    end
    else
    begin
      step_index_o <= on_jog ? 4'h0 : {on_sx, on_sh, on_sm, on_sl};
      ramp_index_o <= {on_rh, on_rm, on_rl};
      jog_o        <= on_jog;
      run_fwd_o    <= on_3w ? fwd_lat_r : on_fwd;
      run_rev_o    <= on_3w ? rev_lat_r : on_rev;
      emergency_stop_o      <= on_estop;
      fault_reset_o         <= rise_rst;
      output_cut_o          <= trip_r || trip_act || on_estop;
      ext_trip_fault_o      <= trip_r;
      dc_injection_brake_o  <= on_dc && drive_stopped_i;
      integral_clear_o      <= on_icl;
      local_remote_select_o <= on_lr;
      analog_hold_o         <= on_ah;
      ramp_stop_o           <= on_rs;
      second_proportional_gain_o <= on_pg2;
      pump_interlock_o      <= lvl8[3:0] & claim_w;
      current_input_sel_o   <= on_ana;
      pre_excite_o          <= (px_r == PX_EXCITE);
      external_pid_enable_o <= on_epid;
      up_down_save_clear_o  <= rise_udc && cfg_r[`PITD_CFG_UD_SAVE];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  a_estop_write_lock: assert property (avs_write_i && ack_r && on_estop |=>
    $stable(filt_ms_r) && $stable(cfg_r) && $stable(maxf_r))
    else $error("register changed during emergency stop");
  a_trip_cut_out: assert property ($rose(trip_act) |=> output_cut_o ##1 ext_trip_fault_o)
    else $error("external trip did not cut output and latch");
  a_jog_index_zero: assert property (jog_o |-> step_index_o == 4'h0)
    else $error("step index not ignored during jog");
  a_updown_max: assert property (up_down_freq_o > maxf_r |=> up_down_freq_o <= maxf_r)
    else $error("up/down frequency above maximum");
  a_contactor_excl: assert property (!(inv_line_contactor_o && comm_line_contactor_o))
    else $error("both line contactors on");
  a_dc_injection_brake_stop: assert property (dc_injection_brake_o |-> $past(drive_stopped_i))
    else $error("dc braking while running");
  a_second_hold: assert property (!drive_stopped_i |=> $stable(second_parameter_set_o))
    else $error("second set changed while running");
  a_sub_board_mask: assert property (!sync2_r[11] |-> status_w[10:8] == 3'h0)
    else $error("sub-board bits shown without sub-board");
  a_filter_range: assert property (filt_ms_r >= `PITD_FILT_MS_MIN
    && filt_ms_r <= `PITD_FILT_MS_MAX)
    else $error("filter constant out of range");
  a_bus_one_wait: assert property (req_w && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held more than one cycle");

  c_trip_latched: cover property ($rose(ext_trip_fault_o));
  c_three_wire:   cover property (on_3w && rise_fwd ##[1:20] run_fwd_o);
  c_pre_normal:   cover property (px_r == PX_EXCITE ##1 px_r == PX_NORMAL);
  c_estop_write:  cover property (avs_write_i && ack_r && on_estop);

endmodule : pitd_top

// ### pitd_top_tb_top.sv
// self-checking bench for the input terminal decoder
`timescale 1ns/1ps
module pitd_top_tb_top;
  logic core_clk_i = 1'b0, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic sub_board_fitted_i, drive_stopped_i, jog_o, run_fwd_o, run_rev_o;
  logic emergency_stop_o, fault_reset_o, output_cut_o, ext_trip_fault_o;
  logic dc_injection_brake_o, second_parameter_set_o, inv_line_contactor_o;
  logic comm_line_contactor_o, integral_clear_o, open_loop_o, local_remote_select_o;
  logic analog_hold_o, ramp_stop_o, second_proportional_gain_o, current_input_sel_o;
  logic pre_excite_o, external_pid_enable_o, up_down_save_clear_o;
  logic [5:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [7:0]  input_terminal_i, want;
  logic [2:0]  sub_board_input_i, sub_want, ramp_index_o;
  logic [3:0]  step_index_o, pump_interlock_o;
  logic [15:0] up_down_freq_o;
  logic [39:0] outs;
  logic [5:0]  def_sel [8] = '{6'h00, 6'h01, 6'h02, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F};
  logic [5:0]  lvl_code [11] = '{6'h06, 6'h07, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14,
                                 6'h20, 6'h22, 6'h21};
  int          lvl_bit [11] = '{10, 9, 8, 7, 6, 5, 4, 3, 2, 0, 1};
  logic [7:0]  n_rst = 8'h00;
  logic [7:0]  n_udc = 8'h00;
  int          fail_count = 0;
  int          checks_done = 0;

  assign outs = {up_down_freq_o, step_index_o, ramp_index_o, jog_o, run_fwd_o, run_rev_o,
    emergency_stop_o, output_cut_o, ext_trip_fault_o, dc_injection_brake_o,
    second_parameter_set_o, integral_clear_o, open_loop_o, local_remote_select_o,
    analog_hold_o, ramp_stop_o, second_proportional_gain_o, current_input_sel_o,
    pre_excite_o, external_pid_enable_o};

  pitd_top #(.CYC_PER_MS(10)) DUT (.*);
  pitd_switches contacts (.clk_i(core_clk_i), .want_i(want), .sub_i(sub_want),
    .term_o(input_terminal_i), .sub_o(sub_board_input_i));

  always #5 core_clk_i = ~core_clk_i;

  // count one-cycle pulses that no level comparison can catch
  always @(posedge core_clk_i)
  begin
    n_rst <= n_rst + 8'(fault_reset_o);
    n_udc <= n_udc + 8'(up_down_save_clear_o);
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one avalon access; waitrequest and read data are taken at the rising edge that ends it
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 40);
    chk("bus ack", 40'h00_0000_0000, {39'h0, avs_waitrequest_o});
    if (n >= 40)
      tally_and_finish();
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk("register", {8'h00, exp}, {8'h00, rd});
  endtask : rdchk

  task automatic await(input string what, input logic [39:0] mask, input logic [39:0] exp);
    int n;
    n = 0;
    while ((outs & mask) !== exp && n < 400)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk(what, exp, outs & mask);
    if (n >= 400)
      tally_and_finish();
  endtask : await

  initial
  begin
    {rst_n_i, avs_read_i, avs_write_i, sub_board_fitted_i, drive_stopped_i} = 5'h00;
    {avs_address_i, avs_writedata_i, want, sub_want} = 49'h0;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++)
      rdchk(4'(i + 1), {26'h0, def_sel[i]});
    rdchk(4'hC, 32'h0000_1770);
    rdchk(4'h9, 32'h0000_000F);
    bus(1'b1, 4'h9, 32'h0000_03E9);
    rdchk(4'h9, 32'h0000_03E8);
    bus(1'b1, 4'h9, 32'h0000_0001);
    rdchk(4'h9, 32'h0000_0002);
    want               <= 8'hC5;
    sub_want           <= 3'b101;
    sub_board_fitted_i <= 1'b1;
    await("step", 40'h00_00F1_C000, 40'h00_0050_C000);
    rdchk(4'h0, 32'h0000_05C5);
    want <= 8'hE5;
    await("jog", 40'h00_00F1_0000, 40'h00_0001_0000);
    want <= 8'h10;
    await("estop", 40'h00_0000_3000, 40'h00_0000_3000);
    bus(1'b1, 4'h9, 32'h0000_0005);
    rdchk(4'h9, 32'h0000_0002);
    want <= 8'h00;
    await("estop off", 40'h00_0000_3000, 40'h00_0000_0000);
    for (int i = 1; i < 4; i++)
      bus(1'b1, 4'(i), 32'(i + 2));
    want <= 8'h86;
    await("ramp", 40'h00_00FE_0000, 40'h00_000C_0000);
    @(posedge core_clk_i);
    drive_stopped_i <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      bus(1'b1, 4'h8, {26'h0, lvl_code[i]});
      await("level", 40'h00_0000_07FF, 40'h00_0000_0001 << lvl_bit[i]);
    end
    bus(1'b1, 4'hC, 32'h0000_0003);
    bus(1'b1, 4'h8, 32'h0000_000A);
    await("up", 40'hFF_FF00_0000, 40'h00_0300_0000);
    // five more ms ticks of up must not pass the ceiling
    repeat (50) @(posedge core_clk_i);
    await("up max", 40'hFF_FF00_0000, 40'h00_0300_0000);
    bus(1'b1, 4'h8, 32'h0000_000D);
    await("trip", 40'h00_0000_1800, 40'h00_0000_1800);
    want[7] <= 1'b0;
    // let the filtered trip level fall before looking at the latch
    repeat (60) @(posedge core_clk_i);
    await("trip held", 40'h00_0000_1800, 40'h00_0000_1800);
    want[3] <= 1'b1;
    await("trip reset", 40'h00_0000_1800, 40'h00_0000_0000);
    repeat (2) @(posedge core_clk_i);
    chk("fault reset pulses", 40'h1, {32'h0, n_rst});
    bus(1'b1, 4'hA, 32'h0000_0004);
    bus(1'b1, 4'h1, 32'h0000_0023);
    want[0] <= 1'b1;
    await("ud clear", 40'hFF_FF00_0000, 40'h00_0000_0000);
    repeat (2) @(posedge core_clk_i);
    chk("ud clear pulses", 40'h1, {32'h0, n_udc});
    bus(1'b1, 4'hA, 32'h0000_0006);
    await("claimed ramp", 40'h00_000E_0000, 40'h00_0000_0000);
    chk("interlock", 40'h00_0000_000F, {36'h0, pump_interlock_o});
    chk("contactors", 40'h2, {38'h0, inv_line_contactor_o, comm_line_contactor_o});
    bus(1'b1, 4'h6, 32'h0000_0008);
    want[5] <= 1'b1;
    repeat (60) @(posedge core_clk_i);
    chk("contactors", 40'h1, {38'h0, inv_line_contactor_o, comm_line_contactor_o});
    bus(1'b1, 4'h8, 32'h0000_000C);
    want[7] <= 1'b1;
    repeat (50) @(posedge core_clk_i);
    want[6] <= 1'b1;
    await("3w start", 40'h00_0000_C000, 40'h00_0000_8000);
    want[6] <= 1'b0;
    repeat (50) @(posedge core_clk_i);
    await("3w held", 40'h00_0000_C000, 40'h00_0000_8000);
    want[7] <= 1'b0;
    await("3w stop", 40'h00_0000_C000, 40'h00_0000_0000);
    @(posedge core_clk_i);
    sub_board_fitted_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rdchk(4'h0, 32'h0000_002F);
    tally_and_finish();
  end
endmodule : pitd_top_tb_top
